// ---- hdl/i2c_bus_watch.sv ----
// Start, stop and bit detector on synchronised SCL and SDA.
`timescale 1ns/1ps
module i2c_bus_watch
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      scl,
    input  wire logic                      sda,
    output i2c_selmon_pkg::bus_event_t     ev
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // SDA moving while SCL is high marks start or stop; SCL rising samples a bit.
    always_comb
    begin
        ev.start     = scl && scl_q && sda_q && !sda;
        ev.stop      = scl && scl_q && !sda_q && sda;
        ev.bit_valid = scl && !scl_q;
        ev.bit_value = sda;
        ev.ack_slot  = 1'b0;
    end
endmodule : i2c_bus_watch

// ---- hdl/i2c_pin_sync.sv ----
// Two-flop synchroniser for one bus pin.
`timescale 1ns/1ps
module i2c_pin_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      pin_sync
);
    logic meta_reg;

    // The first flop feeds only the second one.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            meta_reg <= pin;
            pin_sync <= meta_reg;
        end
    end
endmodule : i2c_pin_sync

// ---- hdl/i2c_selmon.sv ----
// Slave selection and bus monitor status with a simple register port.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "i2c_selmon_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Bits 13:12 report which of four slave addresses matched.
// - Match index only meaningful while the slave is selected.
// - Several simultaneous matches report exactly one, lowest index wins.
// - Selected flag bit 14 sets when software accepts a matched address.
// - Selected clears on non-matching address, software refusal, or Stop.
// - Selected stays set when software refuses a data byte.
// - Deselected flag bit 15 sets on selected falling; interrupt when enabled.
// - Writing one clears deselected; zero leaves it.
// - Monitor ready bit 16 set while data waits; cleared by data read.
// - Overflow bit 17 set on overrun, only when monitor stretching disabled.
// - Writing one clears monitor overflow.
// - Active bit 18 high when Start seen more recently than Stop.
// - Idle bit 19 sets on active to inactive; interrupt when enabled.
// - Idle stays set until software writes one to it.
// - Master refusing a slave-transmitted byte deselects the slave.
module i2c_selmon
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_oe
);
    logic                       scl_s;
    logic                       sda_s;
    i2c_selmon_pkg::bus_event_t ev;
    i2c_selmon_pkg::slave_state_t st_reg;
    logic [7:0]  slave_addr_reg [4];
    logic [7:0]  int_enable_reg;
    logic        mon_stretch_reg;
    logic [1:0]  match_idx_reg;
    logic        sel_reg;
    logic        desel_reg;
    logic        mon_ready_reg;
    logic        mon_ov_reg;
    logic        mon_active_reg;
    logic        mon_idle_reg;
    logic [7:0]  mon_data_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        byte_done;
    logic        addr_phase_reg;
    logic        rw_reg;
    logic        accept_wr;
    logic        refuse_wr;
    logic        any_match;
    logic [1:0]  match_idx;
    logic        sel_next;
    logic        mon_rd;
    logic [31:0] status_word;

    i2c_pin_sync u_scl (.clk(clk), .rst(rst), .pin(scl_in), .pin_sync(scl_s));
    i2c_pin_sync u_sda (.clk(clk), .rst(rst), .pin(sda_in), .pin_sync(sda_s));
    i2c_bus_watch u_watch (.clk(clk), .rst(rst), .scl(scl_s), .sda(sda_s), .ev(ev));

    ////////////////////////////////////////////////////////////////////////////
    // Software strobes decoded from the register port.
    assign accept_wr = wr && addr == `OFS_SLAVE_CTRL && wdata[`BIT_CTRL_CONTINUE];
    assign refuse_wr = wr && addr == `OFS_SLAVE_CTRL && wdata[`BIT_CTRL_REFUSE];
    assign mon_rd    = rd && addr == `OFS_MONITOR_RXDATA;
    assign byte_done = ev.bit_valid && bit_cnt_reg == 4'h7;

    // Address comparison; lowest enabled matching register wins.
    always_comb
    begin
        any_match = 1'b0;
        match_idx = 2'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (slave_addr_reg[i][`BIT_ADDR_ENABLE] && slave_addr_reg[i][6:0] == shift_reg[6:0])
            begin
                any_match = 1'b1;
                match_idx = 2'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and address registers written by software.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            int_enable_reg  <= 8'h00;
            mon_stretch_reg <= 1'b0;
            for (int i = 0; i < 4; i++)
                slave_addr_reg[i] <= 8'h00;
        end
        else if (wr)
        begin
            if (addr == `OFS_INT_ENABLE)
                int_enable_reg <= wdata[`BIT_MON_IDLE:12];
            if (addr == `OFS_CONFIG)
                mon_stretch_reg <= wdata[`BIT_CFG_MON_STRETCH];
            for (int i = 0; i < 4; i++)
                if (addr == 8'(`OFS_SLAVE_ADDR0 + 4 * i))
                    slave_addr_reg[i] <= wdata[7:0];
        end
    end

    // Bit counter and shifter; the ninth bit is the acknowledge slot.
    always_ff @(posedge clk)
    begin
        if (rst || ev.start || ev.stop)
        begin
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            addr_phase_reg <= !rst && ev.start;
        end
        else if (ev.bit_valid)
        begin
            if (bit_cnt_reg == 4'h8)
            begin
                bit_cnt_reg    <= 4'h0;
                addr_phase_reg <= 1'b0;
            end
            else
            begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg   <= {shift_reg[6:0], ev.bit_value};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave sequencing: address match, software decision, data bytes.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg        <= i2c_selmon_pkg::S_IDLE;
            sel_reg       <= 1'b0;
            match_idx_reg <= 2'h0;
            rw_reg        <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next;
            if (ev.stop)
                st_reg <= i2c_selmon_pkg::S_IDLE;
            else if (ev.start)
                st_reg <= i2c_selmon_pkg::S_ADDR;
            else
            begin
                case (st_reg)
                    i2c_selmon_pkg::S_ADDR:
                        if (byte_done && addr_phase_reg)
                        begin
                            rw_reg <= ev.bit_value;
                            if (any_match)
                            begin
                                match_idx_reg <= match_idx;
                                st_reg        <= i2c_selmon_pkg::S_WAIT_SW;
                            end
                            else
                                st_reg <= i2c_selmon_pkg::S_SKIP;
                        end
                    i2c_selmon_pkg::S_WAIT_SW:
                        if (accept_wr)
                            st_reg <= i2c_selmon_pkg::S_DATA;
                        else if (refuse_wr)
                            st_reg <= i2c_selmon_pkg::S_SKIP;
                    i2c_selmon_pkg::S_DATA:
                        if (byte_done)
                            st_reg <= i2c_selmon_pkg::S_ACK;
                    i2c_selmon_pkg::S_ACK:
                        if (ev.bit_valid)
                            st_reg <= (rw_reg && ev.bit_value) ? i2c_selmon_pkg::S_SKIP
                                                               : i2c_selmon_pkg::S_DATA;
                    default:
                        st_reg <= st_reg;
                endcase
            end
        end
    end

    // Selected flag; data refusal by software leaves it set.
    always_comb
    begin
        sel_next = sel_reg;
        if (st_reg == i2c_selmon_pkg::S_WAIT_SW && accept_wr && !ev.stop && !ev.start)
            sel_next = 1'b1;
        if (st_reg == i2c_selmon_pkg::S_WAIT_SW && refuse_wr)
            sel_next = 1'b0;
        if (st_reg == i2c_selmon_pkg::S_ADDR && byte_done && addr_phase_reg && !any_match)
            sel_next = 1'b0;
        if (st_reg == i2c_selmon_pkg::S_ACK && ev.bit_valid && rw_reg && ev.bit_value)
            sel_next = 1'b0;
        if (ev.stop)
            sel_next = 1'b0;
    end

    // This block never drives the acknowledge, so the enable stays low; a flop keeps the output glitch free.
    always_ff @(posedge clk) sda_oe <= 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Deselect flag; a falling edge in the clearing cycle still sets it.
    always_ff @(posedge clk)
    begin
        if (rst)
            desel_reg <= 1'b0;
        else if (sel_reg && !sel_next)
            desel_reg <= 1'b1;
        else if (wr && addr == `OFS_BUS_STATUS && wdata[`BIT_SLAVE_DESEL])
            desel_reg <= 1'b0;
    end

    // Monitor capture of every complete byte on the bus.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mon_ready_reg <= 1'b0;
            mon_ov_reg    <= 1'b0;
            mon_data_reg  <= 8'h00;
        end
        else
        begin
            if (byte_done && bit_cnt_reg == 4'h7)
            begin
                mon_data_reg  <= {shift_reg[6:0], ev.bit_value};
                mon_ready_reg <= 1'b1;
                if (mon_ready_reg && !mon_rd && !mon_stretch_reg)
                    mon_ov_reg <= 1'b1;
            end
            else if (mon_rd)
                mon_ready_reg <= 1'b0;
            if (wr && addr == `OFS_BUS_STATUS && wdata[`BIT_MON_OVERFLOW]
                && !(byte_done && mon_ready_reg && !mon_rd && !mon_stretch_reg))
                mon_ov_reg <= 1'b0;
        end
    end

    // Bus activity and idle event.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mon_active_reg <= 1'b0;
            mon_idle_reg   <= 1'b0;
        end
        else
        begin
            if (ev.start)
                mon_active_reg <= 1'b1;
            else if (ev.stop)
                mon_active_reg <= 1'b0;
            if (mon_active_reg && ev.stop && !ev.start)
                mon_idle_reg <= 1'b1;
            else if (wr && addr == `OFS_BUS_STATUS && wdata[`BIT_MON_IDLE])
                mon_idle_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, registered so data stands in the cycle after the strobe.
    always_comb
    begin
        status_word = `RESET_WORD;
        status_word[13:12]              = sel_reg ? match_idx_reg : 2'h0;
        status_word[`BIT_SLAVE_SEL]     = sel_reg;
        status_word[`BIT_SLAVE_DESEL]   = desel_reg;
        status_word[`BIT_MON_READY]     = mon_ready_reg;
        status_word[`BIT_MON_OVERFLOW]  = mon_ov_reg;
        status_word[`BIT_MON_ACTIVE]    = mon_active_reg;
        status_word[`BIT_MON_IDLE]      = mon_idle_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst || !rd)
            rdata <= 32'h0000_0000;
        else
        begin
            case (addr)
                `OFS_BUS_STATUS:     rdata <= status_word;
                `OFS_INT_ENABLE:     rdata <= {12'h000, int_enable_reg, 12'h000};
                `OFS_CONFIG:         rdata <= {31'h0000_0000, mon_stretch_reg};
                `OFS_MONITOR_RXDATA: rdata <= {24'h00_0000, mon_data_reg};
                default:             rdata <= 32'h0000_0000;
            endcase
        end
    end

    // Interrupt level from enabled sticky flags.
    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= (desel_reg && int_enable_reg[3]) || (mon_idle_reg && int_enable_reg[7])
                   || (mon_ov_reg && int_enable_reg[5]) || (mon_ready_reg && int_enable_reg[4]);
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_active_start;
        @(posedge clk) disable iff (rst) ev.start |=> mon_active_reg;
    endproperty
    a_active_start: assert property (p_active_start) else $error("active not set after start");
    property p_idle_on_stop;
        @(posedge clk) disable iff (rst) (mon_active_reg && ev.stop && !ev.start) |=> mon_idle_reg;
    endproperty
    a_idle_on_stop: assert property (p_idle_on_stop) else $error("idle not set");
    property p_idle_holds;
        @(posedge clk) disable iff (rst) (mon_idle_reg && !(wr && addr == `OFS_BUS_STATUS)) |=> mon_idle_reg;
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("idle lost");
    property p_desel_on_fall;
        @(posedge clk) disable iff (rst) $fell(sel_reg) |-> desel_reg;
    endproperty
    a_desel_on_fall: assert property (p_desel_on_fall) else $error("deselect missed");
    property p_stop_deselects;
        @(posedge clk) disable iff (rst) ev.stop |=> !sel_reg;
    endproperty
    a_stop_deselects: assert property (p_stop_deselects) else $error("stop kept selection");
    property p_ready_clear;
        @(posedge clk) disable iff (rst) (mon_rd && !byte_done) |=> !mon_ready_reg;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");
    property p_no_ov_stretch;
        @(posedge clk) disable iff (rst) (mon_stretch_reg && !mon_ov_reg) |=> !$rose(mon_ov_reg);
    endproperty
    a_no_ov_stretch: assert property (p_no_ov_stretch) else $error("overflow with stretching");
    property p_accept_selects;
        @(posedge clk) disable iff (rst)
            (st_reg == i2c_selmon_pkg::S_WAIT_SW && accept_wr && !refuse_wr && !ev.stop && !ev.start) |=> sel_reg;
    endproperty
    a_accept_selects: assert property (p_accept_selects) else $error("accept did not select");
endmodule : i2c_selmon

// ---- hdl/i2c_selmon_params.svh ----
// Register offsets, field positions and reset values of the slave-select and bus-monitor block.
`ifndef I2C_SELMON_PARAMS_SVH
`define I2C_SELMON_PARAMS_SVH
`define OFS_BUS_STATUS      8'h04
`define OFS_INT_ENABLE      8'h08
`define OFS_CONFIG          8'h0C
`define OFS_SLAVE_CTRL      8'h10
`define OFS_SLAVE_ADDR0     8'h20
`define OFS_MONITOR_RXDATA  8'h30
`define BIT_MATCH_IDX_LO    12
`define BIT_SLAVE_SEL       14
`define BIT_SLAVE_DESEL     15
`define BIT_MON_READY       16
`define BIT_MON_OVERFLOW    17
`define BIT_MON_ACTIVE      18
`define BIT_MON_IDLE        19
`define BIT_CFG_MON_STRETCH 0
`define BIT_CTRL_CONTINUE   0
`define BIT_CTRL_REFUSE     1
`define BIT_ADDR_ENABLE     7
`define RESET_WORD          32'h0000_0000
`endif

// ---- hdl/i2c_selmon_pkg.sv ----
// Types shared by the slave-select and bus-monitor block.
package i2c_selmon_pkg;
    typedef struct packed {
        logic       start;
        logic       stop;
        logic       bit_valid;
        logic       bit_value;
        logic       ack_slot;
    } bus_event_t;
    typedef enum {S_IDLE, S_ADDR, S_WAIT_SW, S_DATA, S_ACK, S_SKIP} slave_state_t;
endpackage : i2c_selmon_pkg

// ---- sim/i2c_bus_master_model.sv ----
// Bus master model that pulls SCL and SDA low as open-drain drivers on the monitored bus.
`timescale 1ns/1ps
module i2c_bus_master_model
(
    output logic scl_low,
    output logic sda_low
);
    // A quarter of the 80 ns bus clock period.
    localparam int QTR = 20;

    // Both lines start released, so the pull-ups hold the bus idle and SCL stands still outside frames.
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start: SDA falls while SCL is high, then SCL is pulled low for the first bit.
    task automatic bus_start();
        sda_low = 1'b1;
        #QTR scl_low = 1'b1;
        #QTR;
    endtask : bus_start

    // One bit: SDA changes only while SCL is low; a released SDA reads as one through the pull-up.
    task automatic clock_bit(input logic v);
        sda_low = ~v;
        #QTR scl_low = 1'b0;
        #(2 * QTR) scl_low = 1'b1;
        #QTR;
    endtask : clock_bit

    // Eight bits, most significant first; SCL is left low so software may answer before the ninth clock.
    task automatic send_bits(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(b[i]);
        end
    endtask : send_bits

    // Stop: SDA rises while SCL is high, leaving both lines released.
    task automatic bus_stop();
        sda_low = 1'b1;
        #QTR scl_low = 1'b0;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask : bus_stop

    // Repeated start from the low phase of SCL.
    task automatic bus_restart();
        sda_low = 1'b0;
        #QTR scl_low = 1'b0;
        #QTR;
        bus_start();
    endtask : bus_restart
endmodule : i2c_bus_master_model

// ---- sim/i2c_selmon_tb_top.sv ----
// Self-checking bench for the slave-select and bus-monitor status block.
`timescale 1ns/1ps
`include "i2c_selmon_params.svh"
module i2c_selmon_tb_top;
    localparam logic [31:0] SEL   = 32'h0000_0001 << `BIT_SLAVE_SEL;
    localparam logic [31:0] DESEL = 32'h0000_0001 << `BIT_SLAVE_DESEL;
    localparam logic [31:0] RDY   = 32'h0000_0001 << `BIT_MON_READY;
    localparam logic [31:0] OV    = 32'h0000_0001 << `BIT_MON_OVERFLOW;
    localparam logic [31:0] ACT   = 32'h0000_0001 << `BIT_MON_ACTIVE;
    localparam logic [31:0] IDLE  = 32'h0000_0001 << `BIT_MON_IDLE;
    localparam logic [31:0] IDX1  = 32'h0000_0001 << `BIT_MATCH_IDX_LO;
    localparam logic [7:0]  STS   = `OFS_BUS_STATUS;

    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] rd_val;
    logic        irq;
    logic        dut_sda_oe;
    logic        m_scl_low;
    logic        m_sda_low;
    wire         scl_w;
    wire         sda_w;
    int          error_cnt;
    int          checks_done;

    // Pull-ups: a line is low only while some party pulls it.
    assign scl_w = ~m_scl_low;
    assign sda_w = ~(m_sda_low | dut_sda_oe);

    i2c_selmon u_i2c_selmon
    (
        .clk    (clk),
        .rst    (rst),
        .addr   (addr),
        .wdata  (wdata),
        .wr     (wr),
        .rd     (rd),
        .rdata  (rdata),
        .irq    (irq),
        .scl_in (scl_w),
        .sda_in (sda_w),
        .sda_oe (dut_sda_oe)
    );

    i2c_bus_master_model u_i2c_bus_master_model
    (
        .scl_low (m_scl_low),
        .sda_low (m_sda_low)
    );

    // Free-running 250 MHz clock.
    initial clk = 1'b0;
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one word and count it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe; the next access waits for a fresh edge, so no strobe is assigned twice at once.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        chk(rd_val, exp);
    endtask : rd_chk

    // Ten cycles cover the two-flop synchroniser, the detector and the registered interrupt.
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask : settle

    task automatic irq_chk(input logic e);
        chk({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask : irq_chk

    // One byte with its ninth clock; a nonzero control word answers while SCL is held low.
    task automatic byte_phase(input logic [7:0] b, input logic [31:0] ctl);
        u_i2c_bus_master_model.send_bits(b);
        if (ctl != 32'h0000_0000)
        begin
            wr_reg(`OFS_SLAVE_CTRL, ctl);
        end
        u_i2c_bus_master_model.clock_bit(1'b1);
        settle();
    endtask : byte_phase

    task automatic drain(input logic [7:0] b);
        rd_chk(`OFS_MONITOR_RXDATA, {24'h00_0000, b});
    endtask : drain

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs about 8 us of bus traffic.
    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end

    // Main sequence.
    initial
    begin
        error_cnt   = 0;
        checks_done = 0;
        rst   = 1'b1;
        addr  = 8'h00;
        wdata = 32'h0000_0000;
        wr    = 1'b0;
        rd    = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(STS, 32'h0000_0000);
        rd_chk(8'h3C, 32'h0000_0000);
        // Address 0 holds the same address but is disabled; 1 and 2 both match, so the lowest enabled wins.
        wr_reg(`OFS_SLAVE_ADDR0, 32'h0000_0055);
        wr_reg(`OFS_SLAVE_ADDR0 + 8'h04, 32'h0000_00D5);
        wr_reg(`OFS_SLAVE_ADDR0 + 8'h08, 32'h0000_00D5);
        wr_reg(`OFS_CONFIG, 32'h0000_0000);
        u_i2c_bus_master_model.bus_start();
        settle();
        rd_chk(STS, ACT);
        byte_phase(8'hAA, 32'h0000_0001);
        rd_chk(STS, ACT | SEL | RDY | IDX1);
        chk({31'h0000_0000, dut_sda_oe}, 32'h0000_0000);
        drain(8'hAA);
        rd_chk(STS, ACT | SEL | IDX1);
        byte_phase(8'h3C, 32'h0000_0002);
        rd_chk(STS, ACT | SEL | RDY | IDX1);
        byte_phase(8'h5A, 32'h0000_0000);
        rd_chk(STS, ACT | SEL | RDY | OV | IDX1);
        wr_reg(STS, OV);
        rd_chk(STS, ACT | SEL | RDY | IDX1);
        drain(8'h5A);
        u_i2c_bus_master_model.bus_stop();
        settle();
        rd_chk(STS, DESEL | IDLE);
        irq_chk(1'b0);
        wr_reg(`OFS_INT_ENABLE, DESEL);
        rd_chk(`OFS_INT_ENABLE, DESEL);
        settle();
        irq_chk(1'b1);
        wr_reg(STS, 32'h0000_0000);
        rd_chk(STS, DESEL | IDLE);
        wr_reg(STS, DESEL);
        settle();
        irq_chk(1'b0);
        rd_chk(STS, IDLE);
        wr_reg(`OFS_INT_ENABLE, IDLE);
        settle();
        irq_chk(1'b1);
        wr_reg(STS, IDLE);
        settle();
        irq_chk(1'b0);
        // Software refuses the matched address: never selected, so no deselect event either.
        u_i2c_bus_master_model.bus_start();
        byte_phase(8'hAA, 32'h0000_0002);
        rd_chk(STS, ACT | RDY);
        drain(8'hAA);
        // Read transfer: the master refuses the slave's byte, which drops the selection.
        u_i2c_bus_master_model.bus_restart();
        byte_phase(8'hAB, 32'h0000_0001);
        rd_chk(STS, ACT | SEL | RDY | IDX1);
        drain(8'hAB);
        u_i2c_bus_master_model.send_bits(8'hFF);
        u_i2c_bus_master_model.clock_bit(1'b1);
        settle();
        rd_chk(STS, ACT | DESEL | RDY);
        drain(8'hFF);
        wr_reg(STS, DESEL);
        // A later address cycle that matches nothing drops the selection.
        u_i2c_bus_master_model.bus_restart();
        byte_phase(8'hAA, 32'h0000_0001);
        drain(8'hAA);
        u_i2c_bus_master_model.bus_restart();
        byte_phase(8'h22, 32'h0000_0000);
        rd_chk(STS, ACT | DESEL | RDY);
        // With monitor stretching on, a byte landing on unread data raises no overflow.
        wr_reg(`OFS_CONFIG, 32'h0000_0001);
        rd_chk(`OFS_CONFIG, 32'h0000_0001);
        byte_phase(8'h66, 32'h0000_0000);
        rd_chk(STS, ACT | DESEL | RDY);
        drain(8'h66);
        u_i2c_bus_master_model.bus_stop();
        settle();
        irq_chk(1'b1);
        conclude();
    end
endmodule : i2c_selmon_tb_top
